// *** ldcsr_map.svh ***
// register offsets, field positions, reset values and timing counts of the control block
`ifndef LDCSR_MAP_SVH
`define LDCSR_MAP_SVH
`define LDCSR_ADDR_SHDN 8'h09
`define LDCSR_ADDR_WDOG 8'h0A
`define LDCSR_ADDR_CSYNC 8'h0B
`define LDCSR_ADDR_ICAUSE 8'h0E
`define LDCSR_RST_SHDN 8'h02
`define LDCSR_RST_WDOG 8'hFF
`define LDCSR_RST_CSYNC 8'h00
`define LDCSR_RST_ICAUSE 8'h20
`define LDCSR_BIT_SHDN 0
`define LDCSR_BIT_INIT 1
`define LDCSR_BIT_MANTEST 2
`define LDCSR_BIT_AUTOTEST 3
`define LDCSR_BIT_TESTALL 4
`define LDCSR_BIT_MONITOR 0
`define LDCSR_BIT_SYNCIN 0
`define LDCSR_BIT_SYNCOUT 1
`define LDCSR_BIT_FRAME 7
`define LDCSR_BIT_DEADLOCK 6
`define LDCSR_BIT_POR 5
`define LDCSR_BIT_OVERTEMP 4
`define LDCSR_BIT_LOWVDD 3
`define LDCSR_BIT_OPEN 2
`define LDCSR_BIT_SHORT 1
`define LDCSR_BIT_MOVIE 0
`define LDCSR_CLK_HZ 20000000
`define LDCSR_CLK_PERIOD_NS 50
`define LDCSR_WD_UNIT_NS 256000
`define LDCSR_WD_TICK_CYCLES (`LDCSR_WD_UNIT_NS / `LDCSR_CLK_PERIOD_NS)
`define LDCSR_F_1M 1000000
`define LDCSR_F_500K 500000
`define LDCSR_F_125K 125000
`define LDCSR_F_32K 32000
`define LDCSR_HALF(f) (`LDCSR_CLK_HZ / (2 * (f)))
`endif

// *** ldcsr_pkg.sv ***
// types shared by the led driver control and status registers
`default_nettype none
package ldcsr_pkg;
  typedef enum logic [1:0] {CLK_1M, CLK_500K, CLK_125K, CLK_32K} ldcsr_clksel_t;
  typedef struct packed {
    logic frameShown;
    logic overTemp;
    logic lowVdd;
    logic openErr;
    logic shortErr;
    logic movieDone;
  } ldcsr_events_t;
  typedef struct packed {
    logic testAll;
    logic autoTest;
    logic manualTest;
    logic run;
    logic shutdown;
  } ldcsr_shdn_t;
endpackage
`default_nettype wire

// *** ldcsr_regs.sv ***
// control and status registers of the led matrix driver
//
// Overview of operation
// - shutdown bit kills outputs, halts state machine
// - writing init zero reinitialises control logic
// - manual test starts on shutdown register write
// - auto test starts on picture/movie start
// - test-all bit sets open/short test coverage
// - test covers scan-limit segments only
// - monitored bus deadlock resets serial interface
// - timeout equals code plus one times 256us
// - clock select picks sync pin frequency
// - sync out drives selected clock on pin
// - sync in disables oscillator, uses pin
// - cause read restores default, releases irq
// - cause register resets to 0x20
// - bit 7 flags selected frame displayed
// - bit 6 flags bus watchdog deadlock
// - bit 4 flags overtemperature
// - bit 3 flags supply too low
// - bit 2 open error, bit 1 short
// - bit 0 flags movie finished
// - mask enables each cause onto irq
`include "ldcsr_map.svh"
`default_nettype none
module ldcsr_regs #(
  parameter int WD_TICK_CYCLES = `LDCSR_WD_TICK_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port from the serial interface
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  output logic [7:0] regRdata,
  // display core
  input wire logic [3:0] scanLimit,
  input wire logic showPicSet,
  input wire logic showMovieSet,
  input wire ldcsr_pkg::ldcsr_events_t events,
  input wire logic [7:0] irqMask,
  output logic ledOutEnable,
  output logic fsmRun,
  output logic fsmReinit,
  output logic testStart,
  output logic testAll,
  output logic [3:0] testSegments,
  // serial bus pins and interface reset
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic busReset,
  // clock synchronisation
  output logic oscEnable,
  output logic sysClkFromPin,
  output logic syncPinOut,
  output logic syncPinOe,
  // interrupt request, active high
  output logic irq
);
  logic [7:0] shdnReg_q;
  logic [7:0] wdogReg_q;
  logic [7:0] csyncReg_q;
  logic [7:0] cause_q;
  logic porIrq_q;
  ldcsr_pkg::ldcsr_shdn_t shdn;
  logic wrShdn, wrWdog, wrCsync, rdCause;
  logic [7:0] causeSet;
  logic deadlock;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    hit = (a == b);
  endfunction

  assign wrShdn = regWr && hit(regAddr, `LDCSR_ADDR_SHDN);
  assign wrWdog = regWr && hit(regAddr, `LDCSR_ADDR_WDOG);
  assign wrCsync = regWr && hit(regAddr, `LDCSR_ADDR_CSYNC);
  assign rdCause = regRd && hit(regAddr, `LDCSR_ADDR_ICAUSE);
  assign shdn = ldcsr_pkg::ldcsr_shdn_t'(shdnReg_q[4:0]);

  // control registers; reserved bits are not stored
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      shdnReg_q <= `LDCSR_RST_SHDN;
      wdogReg_q <= `LDCSR_RST_WDOG;
      csyncReg_q <= `LDCSR_RST_CSYNC;
    end
    else
    begin
      if (wrShdn)
        shdnReg_q <= {3'h0, regWdata[4:0]};
      if (wrWdog)
        wdogReg_q <= regWdata;
      if (wrCsync)
        csyncReg_q <= {4'h0, regWdata[3:0]};
    end
  end

  // read data; unmapped offsets answer zero
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      regRdata <= 8'h00;
    else if (regRd)
    begin
      if (hit(regAddr, `LDCSR_ADDR_SHDN))
        regRdata <= shdnReg_q;
      else if (hit(regAddr, `LDCSR_ADDR_WDOG))
        regRdata <= wdogReg_q;
      else if (hit(regAddr, `LDCSR_ADDR_CSYNC))
        regRdata <= csyncReg_q;
      else if (hit(regAddr, `LDCSR_ADDR_ICAUSE))
        regRdata <= cause_q;
      else
        regRdata <= 8'h00;
    end
  end

  assign ledOutEnable = !shdn.shutdown;
  assign fsmRun = shdn.run && !shdn.shutdown;

  // init written low restarts the core; the bit stays low until software sets it again
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      fsmReinit <= 1'b0;
    else
      fsmReinit <= wrShdn && !regWdata[`LDCSR_BIT_INIT];
  end

  // test start: manual on the register update, automatic on display start
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      testStart <= 1'b0;
    else
      testStart <= (wrShdn && regWdata[`LDCSR_BIT_MANTEST])
        || (shdn.autoTest && (showPicSet || showMovieSet));
  end

  assign testAll = shdn.testAll;
  assign testSegments = scanLimit;

  // bus pins are asynchronous to clk
  logic sclMeta, sclSync, sclPrev, sdaMeta, sdaSync, sdaPrev;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sclMeta <= 1'b1;
      sclSync <= 1'b1;
      sclPrev <= 1'b1;
      sdaMeta <= 1'b1;
      sdaSync <= 1'b1;
      sdaPrev <= 1'b1;
    end
    else
    begin
      sclMeta <= sclIn;
      sclSync <= sclMeta;
      sclPrev <= sclSync;
      sdaMeta <= sdaIn;
      sdaSync <= sdaMeta;
      sdaPrev <= sdaSync;
    end
  end

  // watchdog: a 256us tick base, then code+1 ticks with data low and no edge
  logic busActivity, wdArmed;
  logic [15:0] tickCnt_q;
  logic [7:0] unitCnt_q;
  logic [7:0] wdLimit;
  assign busActivity = (sclSync != sclPrev) || (sdaSync != sdaPrev);
  assign wdArmed = wdogReg_q[`LDCSR_BIT_MONITOR] && !sdaSync && !busActivity;
  assign wdLimit = {1'b0, wdogReg_q[7:1]} + 8'h01;
  assign deadlock = wdArmed && (tickCnt_q == 16'(WD_TICK_CYCLES - 1))
    && (unitCnt_q == wdLimit - 8'h01);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      tickCnt_q <= 16'h0000;
      unitCnt_q <= 8'h00;
    end
    else if (!wdArmed || deadlock)
    begin
      tickCnt_q <= 16'h0000;
      unitCnt_q <= 8'h00;
    end
    else if (tickCnt_q == 16'(WD_TICK_CYCLES - 1))
    begin
      tickCnt_q <= 16'h0000;
      unitCnt_q <= unitCnt_q + 8'h01;
    end
    else
      tickCnt_q <= tickCnt_q + 16'h0001;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      busReset <= 1'b0;
    else
      busReset <= deadlock;
  end

  // sync pin: sync in wins if software sets both, so the pin is never driven as a clock input
  assign sysClkFromPin = csyncReg_q[`LDCSR_BIT_SYNCIN];
  assign oscEnable = !csyncReg_q[`LDCSR_BIT_SYNCIN];
  assign syncPinOe = csyncReg_q[`LDCSR_BIT_SYNCOUT] && !csyncReg_q[`LDCSR_BIT_SYNCIN];

  logic [8:0] divCnt_q;
  logic [8:0] divHalf;
  always_comb
  begin
    case (ldcsr_pkg::ldcsr_clksel_t'(csyncReg_q[3:2]))
      ldcsr_pkg::CLK_1M: divHalf = 9'(`LDCSR_HALF(`LDCSR_F_1M));
      ldcsr_pkg::CLK_500K: divHalf = 9'(`LDCSR_HALF(`LDCSR_F_500K));
      ldcsr_pkg::CLK_125K: divHalf = 9'(`LDCSR_HALF(`LDCSR_F_125K));
      default: divHalf = 9'(`LDCSR_HALF(`LDCSR_F_32K)); // 32kHz rounds to 312 cycles
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      divCnt_q <= 9'h000;
      syncPinOut <= 1'b0;
    end
    else if (!syncPinOe)
    begin
      divCnt_q <= 9'h000;
      syncPinOut <= 1'b0;
    end
    else if (divCnt_q >= divHalf - 9'h001)
    begin
      divCnt_q <= 9'h000;
      syncPinOut <= !syncPinOut;
    end
    else
      divCnt_q <= divCnt_q + 9'h001;
  end

  // interrupt cause: set wins over the read clear
  always_comb
  begin
    causeSet = 8'h00;
    causeSet[`LDCSR_BIT_FRAME] = events.frameShown;
    causeSet[`LDCSR_BIT_DEADLOCK] = deadlock;
    causeSet[`LDCSR_BIT_OVERTEMP] = events.overTemp;
    causeSet[`LDCSR_BIT_LOWVDD] = events.lowVdd;
    causeSet[`LDCSR_BIT_OPEN] = events.openErr;
    causeSet[`LDCSR_BIT_SHORT] = events.shortErr;
    causeSet[`LDCSR_BIT_MOVIE] = events.movieDone;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      cause_q <= `LDCSR_RST_ICAUSE;
    else if (rdCause)
      cause_q <= `LDCSR_RST_ICAUSE | causeSet;
    else
      cause_q <= cause_q | causeSet;
  end

  // the restored power-on bit after a read must not raise irq again
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      porIrq_q <= 1'b1;
    else if (rdCause)
      porIrq_q <= 1'b0;
  end

  logic [7:0] causeLive;
  always_comb
  begin
    causeLive = cause_q;
    causeLive[`LDCSR_BIT_POR] = cause_q[`LDCSR_BIT_POR] && porIrq_q;
  end
  assign irq = |(causeLive & irqMask);

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_shutdown_off;
    shdn.shutdown |-> !ledOutEnable && !fsmRun;
  endproperty
  a_shutdown_off: assert property (p_shutdown_off) else $error("outputs on in shutdown");

  property p_reinit;
    wrShdn && !regWdata[`LDCSR_BIT_INIT] |=> fsmReinit && !fsmRun;
  endproperty
  a_reinit: assert property (p_reinit) else $error("init low did not reinit");

  property p_manual_test;
    wrShdn && regWdata[`LDCSR_BIT_MANTEST] |=> testStart;
  endproperty
  a_manual_test: assert property (p_manual_test) else $error("manual test not started");

  property p_auto_test;
    shdn.autoTest && (showPicSet || showMovieSet) |=> testStart;
  endproperty
  a_auto_test: assert property (p_auto_test) else $error("auto test not started");

  property p_no_spurious_test;
    testStart |-> $past(wrShdn) || $past(showPicSet) || $past(showMovieSet);
  endproperty
  a_no_spurious_test: assert property (p_no_spurious_test)
    else $error("test start without cause");

  property p_busreset_cause;
    busReset |-> $past(wdogReg_q[`LDCSR_BIT_MONITOR]) && !$past(sdaSync);
  endproperty
  a_busreset_cause: assert property (p_busreset_cause)
    else $error("bus reset without deadlock");

  property p_activity_restart;
    busActivity |=> tickCnt_q == 16'h0000 && unitCnt_q == 8'h00;
  endproperty
  a_activity_restart: assert property (p_activity_restart)
    else $error("watchdog not restarted");

  property p_sync_exclusive;
    sysClkFromPin |-> !syncPinOe && !oscEnable;
  endproperty
  a_sync_exclusive: assert property (p_sync_exclusive)
    else $error("sync pin driven as input");

  property p_read_restore;
    rdCause && causeSet == 8'h00 |=> cause_q == `LDCSR_RST_ICAUSE && !porIrq_q;
  endproperty
  a_read_restore: assert property (p_read_restore)
    else $error("cause not restored on read");

  property p_deadlock_flag;
    deadlock |=> cause_q[`LDCSR_BIT_DEADLOCK] && busReset;
  endproperty
  a_deadlock_flag: assert property (p_deadlock_flag)
    else $error("deadlock not flagged");

  // a read in the same cycle must not lose the flag, since the set wins
  property p_event_sticky;
    events.overTemp |=> cause_q[`LDCSR_BIT_OVERTEMP];
  endproperty
  a_event_sticky: assert property (p_event_sticky) else $error("overtemp flag lost");

  property p_irq_mask;
    rdCause && causeSet == 8'h00 |=> !irq;
  endproperty
  a_irq_mask: assert property (p_irq_mask)
    else $error("irq held after cause read");
endmodule
`default_nettype wire

// *** ldcsr_host_model.sv ***
// serial bus master model driving the bus pins seen by the register block
`default_nettype none
module ldcsr_host_model (
  // clock
  input wire logic clk,
  // 0 released, 1 data line stuck low, 2 clocking with data low
  input wire logic [1:0] mode,
  // bus pins
  output logic scl,
  output logic sda
);
  timeunit 1ns;
  timeprecision 1ns;
  logic sclTog_q = 1'b0;
  always @(posedge clk)
  begin
    sclTog_q <= ~sclTog_q;
  end
  // released lines float to their pull-up level
  assign scl = (mode == 2'h2) ? sclTog_q : 1'b1;
  assign sda = (mode == 2'h0);
endmodule
`default_nettype wire

// *** led_driver_control_status_regs_bench.sv ***
// self-checking bench of the control and status registers
`default_nettype none
module led_driver_control_status_regs_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWdata = 8'h00;
  logic [7:0] regRdata;
  logic [3:0] scanLimit = 4'h3;
  logic showPicSet = 1'b0;
  logic showMovieSet = 1'b0;
  ldcsr_pkg::ldcsr_events_t events = '0;
  logic [7:0] irqMask = 8'h20;
  logic ledOutEnable, fsmRun, fsmReinit, testStart, testAll, busReset;
  logic oscEnable, sysClkFromPin, syncPinOut, syncPinOe, irq, sclIn, sdaIn;
  logic [3:0] testSegments;
  logic [1:0] mode = 2'h0;
  int n_mismatch = 0;
  int n_compared = 0;
  always #25 clk = ~clk;
  ldcsr_host_model host (.clk(clk), .mode(mode), .scl(sclIn), .sda(sdaIn));
  // short watchdog tick keeps the deadlock scenario brief
  ldcsr_regs #(.WD_TICK_CYCLES(4)) dut (.clk(clk), .rst(rst), .regWr(regWr), .regRd(regRd),
    .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata), .scanLimit(scanLimit),
    .showPicSet(showPicSet), .showMovieSet(showMovieSet), .events(events),
    .irqMask(irqMask), .ledOutEnable(ledOutEnable), .fsmRun(fsmRun),
    .fsmReinit(fsmReinit), .testStart(testStart), .testAll(testAll),
    .testSegments(testSegments), .sclIn(sclIn), .sdaIn(sdaIn), .busReset(busReset),
    .oscEnable(oscEnable), .sysClkFromPin(sysClkFromPin), .syncPinOut(syncPinOut),
    .syncPinOe(syncPinOe), .irq(irq));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1 d = regRdata;
  endtask
  task automatic t_reset();
    logic [7:0] d;
    check(irq, 1'b1);
    rd(8'h09, d);
    check(d, 8'h02);
    rd(8'h0A, d);
    check(d, 8'hFF);
    rd(8'h0B, d);
    check(d, 8'h00);
    rd(8'h0E, d);
    check(d, 8'h20);
    check(irq, 1'b0);
    rd(8'h30, d);
    check(d, 8'h00);
  endtask
  // a device reset in mid-run must bring back the power-on state and irq
  task automatic t_rerst();
    @(posedge clk);
    rst <= 1'b1;
    irqMask <= 8'h20;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1 t_reset();
  endtask
  task automatic t_shdn();
    logic [7:0] d;
    wr(8'h09, 8'hFF);
    check({testStart, fsmReinit, ledOutEnable, fsmRun, testAll}, 5'b10001);
    rd(8'h09, d); check(d, 8'h1F);
    wr(8'h09, 8'h04);
    check({testStart, fsmReinit, ledOutEnable, fsmRun}, 4'b1110);
  endtask
  task automatic t_auto(input logic [7:0] v, input logic exp);
    wr(8'h09, v);
    check(testStart, 1'b0);
    @(posedge clk);
    scanLimit <= v[3:0];
    showMovieSet <= 1'b1;
    @(posedge clk);
    showMovieSet <= 1'b0;
    showPicSet <= 1'b1;
    #1 check(testStart, exp);
    @(posedge clk);
    showPicSet <= 1'b0;
    #1 check(testStart, exp);
    check(testSegments, v[3:0]);
  endtask
  task automatic t_events();
    logic [7:0] d;
    int bitPos [6] = '{7, 4, 3, 2, 1, 0};
    for (int i = 0; i < 7; i++)
    begin
      @(posedge clk);
      irqMask <= (i < 6) ? 8'h01 << bitPos[i] : 8'h00;
      events <= 6'h20 >> (i % 6);
      @(posedge clk);
      events <= '0;
      #1 check(irq, i < 6);
      rd(8'h0E, d);
      check(d, 8'h20 | (8'h01 << bitPos[i % 6]));
      rd(8'h0E, d);
      check({d, irq}, {8'h20, 1'b0});
    end
  endtask
  task automatic t_wdog();
    logic [7:0] d;
    int n = 0;
    wr(8'h0A, 8'h03);
    @(posedge clk);
    mode <= 2'h2;
    repeat (40)
    begin
      @(posedge clk);
      #1 if (busReset !== 1'b0) n++;
    end
    check(n, 0);
    @(posedge clk);
    mode <= 2'h1;
    n = 0;
    while (busReset !== 1'b1 && n < 60)
    begin
      @(posedge clk);
      #1 n++;
    end
    // eight armed cycles of code 1, plus pin synchronisers and the pulse flop
    check(n >= 9 && n <= 13, 1'b1);
    @(posedge clk);
    mode <= 2'h0;
    rd(8'h0E, d);
    check(d, 8'h60);
  endtask
  task automatic t_sync();
    int half [4] = '{10, 20, 80, 312};
    int n;
    logic s;
    for (int k = 0; k < 4; k++)
    begin
      wr(8'h0B, {4'h0, 2'(k), 2'b10});
      check({syncPinOe, oscEnable, sysClkFromPin}, 3'b110);
      s = syncPinOut;
      n = 0;
      while (syncPinOut === s && n < 700)
      begin
        @(posedge clk);
        #1 n++;
      end
      s = syncPinOut;
      n = 0;
      while (syncPinOut === s && n < 700)
      begin
        @(posedge clk);
        #1 n++;
      end
      check(n, half[k]);
    end
    wr(8'h0B, 8'h01);
    check({syncPinOe, oscEnable, sysClkFromPin}, 3'b001);
  endtask
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    #400000;
    n_mismatch++;
    end_of_test();
  end
  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    #1;
    t_reset();
    t_shdn();
    t_auto(8'h0A, 1'b1);
    t_auto(8'h02, 1'b0);
    t_events();
    t_wdog();
    t_sync();
    t_rerst();
    end_of_test();
  end
endmodule
`default_nettype wire
